/* calendar_pkg.sv */
// constants, types and helper functions for the calendar clock
package calendar_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 14;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SECONDS = 14'h2015;
  localparam logic [IDX_W-1:0] IDX_MINUTES = 14'h2016;
  localparam logic [IDX_W-1:0] IDX_HOURS   = 14'h2017;
  localparam logic [IDX_W-1:0] IDX_WEEKDAY = 14'h2018;
  localparam logic [IDX_W-1:0] IDX_DATE    = 14'h2019;
  localparam logic [IDX_W-1:0] IDX_MONTH   = 14'h201A;
  localparam logic [IDX_W-1:0] IDX_YEAR    = 14'h201B;
  localparam logic [IDX_W-1:0] IDX_TRIM    = 14'h201C;

  localparam int SEC_W = 6;
  localparam int MIN_W = 6;
  localparam int HR_W  = 5;
  localparam int WD_W  = 3;
  localparam int DT_W  = 5;
  localparam int MO_W  = 4;
  localparam int YR_W  = 8;

  localparam int TRIM_INSERT_BIT = 0;
  localparam int TRIM_REMOVE_BIT = 1;

  localparam logic [SEC_W-1:0] SEC_MAX   = 6'h3B;
  localparam logic [MIN_W-1:0] MIN_MAX   = 6'h3B;
  localparam logic [HR_W-1:0]  HR_MAX    = 5'h17;
  localparam logic [WD_W-1:0]  WD_FIRST  = 3'h1;
  localparam logic [WD_W-1:0]  WD_LAST   = 3'h7;
  localparam logic [DT_W-1:0]  DT_FIRST  = 5'h01;
  localparam logic [DT_W-1:0]  DT_31     = 5'h1F;
  localparam logic [DT_W-1:0]  DT_30     = 5'h1E;
  localparam logic [DT_W-1:0]  DT_29     = 5'h1D;
  localparam logic [DT_W-1:0]  DT_28     = 5'h1C;
  localparam logic [MO_W-1:0]  MO_FIRST  = 4'h1;
  localparam logic [MO_W-1:0]  MO_LAST   = 4'hC;
  localparam logic [MO_W-1:0]  MO_FEB    = 4'h2;
  localparam logic [MO_W-1:0]  MO_APR    = 4'h4;
  localparam logic [MO_W-1:0]  MO_JUN    = 4'h6;
  localparam logic [MO_W-1:0]  MO_SEP    = 4'h9;
  localparam logic [MO_W-1:0]  MO_NOV    = 4'hB;
  localparam logic [YR_W-1:0]  YR_MAX    = 8'hFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [YR_W-1:0]  year;
    logic [MO_W-1:0]  month;
    logic [DT_W-1:0]  date;
    logic [WD_W-1:0]  weekday;
    logic [HR_W-1:0]  hours;
    logic [MIN_W-1:0] minutes;
    logic [SEC_W-1:0] seconds;
  } calendar_t;

  localparam calendar_t CAL_RESET = '{year: 8'h00, month: 4'h1, date: 5'h01, weekday: 3'h1,
                                      hours: 5'h00, minutes: 6'h00, seconds: 6'h00};

  typedef struct packed {
    logic             hit_sec;
    logic             hit_min;
    logic             hit_hr;
    logic             hit_wd;
    logic             hit_dt;
    logic             hit_mo;
    logic             hit_yr;
    logic             hit_trim;
  } reg_hits_t;

  function automatic reg_hits_t decode_index(input logic [IDX_W-1:0] idx);
    reg_hits_t h;
    h.hit_sec  = (idx == IDX_SECONDS);
    h.hit_min  = (idx == IDX_MINUTES);
    h.hit_hr   = (idx == IDX_HOURS);
    h.hit_wd   = (idx == IDX_WEEKDAY);
    h.hit_dt   = (idx == IDX_DATE);
    h.hit_mo   = (idx == IDX_MONTH);
    h.hit_yr   = (idx == IDX_YEAR);
    h.hit_trim = (idx == IDX_TRIM);
    return h;
  endfunction

endpackage

/* second_trim.sv */
// holds one pending second correction and turns ticks into calendar steps
`timescale 1ns/1ps
module second_trim
  import calendar_pkg::*;
(
  input  wire logic aclk,        // system clock
  input  wire logic aresetn,     // synchronous reset, low active
  input  wire logic sec_tick,    // one-cycle seconds tick
  input  wire logic insert_req,  // software asked for one extra second
  input  wire logic remove_req,  // software asked to drop one second
  output logic      step         // one-cycle calendar advance
);

  logic insert_q;
  logic remove_q;
  logic extra_q;
  logic insert_now;
  logic remove_now;

  // a request landing on the tick cycle is used right away, not lost
  assign insert_now = insert_q | insert_req;
  assign remove_now = remove_q | remove_req;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      insert_q <= 1'b0;
      remove_q <= 1'b0;
      extra_q  <= 1'b0;
    end
    else
    begin
      insert_q <= sec_tick ? 1'b0 : insert_now;
      remove_q <= sec_tick ? 1'b0 : remove_now;
      extra_q  <= sec_tick & insert_now & ~remove_now;
    end
  end

  // removal swallows the tick; insertion adds a second step one cycle later
  assign step = (sec_tick & ~remove_now) | extra_q;

endmodule

/* calendar_clock_with_trim.sv */
// calendar clock with second trim, registers over AXI4-Lite
`timescale 1ns/1ps
module calendar_clock_with_trim
  import calendar_pkg::*;
(
  input  wire logic              aclk,          // system clock, 250 MHz
  input  wire logic              aresetn,       // synchronous reset, low active
  input  wire logic              sec_tick,      // one-cycle seconds tick from time base
  input  wire logic [ADDR_W-1:0] s_awaddr,      // write address
  input  wire logic [2:0]        s_awprot,      // write protection, unused
  input  wire logic              s_awvalid,     // write address valid
  output logic                   s_awready,     // write address ready
  input  wire logic [DATA_W-1:0] s_wdata,       // write data
  input  wire logic [3:0]        s_wstrb,       // write byte enables
  input  wire logic              s_wvalid,      // write data valid
  output logic                   s_wready,      // write data ready
  output logic [1:0]             s_bresp,       // write response
  output logic                   s_bvalid,      // write response valid
  input  wire logic              s_bready,      // write response ready
  input  wire logic [ADDR_W-1:0] s_araddr,      // read address
  input  wire logic [2:0]        s_arprot,      // read protection, unused
  input  wire logic              s_arvalid,     // read address valid
  output logic                   s_arready,     // read address ready
  output logic [DATA_W-1:0]      s_rdata,       // read data
  output logic [1:0]             s_rresp,       // read response
  output logic                   s_rvalid,      // read data valid
  input  wire logic              s_rready,      // read data ready
  output calendar_t              calendar_now   // current time and date
);

  // write channel capture
  logic              aw_held_q;
  logic [IDX_W-1:0]  aw_idx_q;
  logic              w_held_q;
  logic [DATA_W-1:0] w_data_q;
  logic              w_lane0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;

  // read channel
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;

  calendar_t         cal_q;
  calendar_t         cal_d;
  calendar_t         cal_stepped;

  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_fire;
  logic              wr_apply;
  reg_hits_t         wr_hit;
  reg_hits_t         rd_hit;
  logic              wr_mapped;
  logic              rd_mapped;
  logic [DATA_W-1:0] rd_value;
  logic              insert_req;
  logic              remove_req;
  logic              trim_both;
  logic              step;
  logic              aw_held_d;
  logic              w_held_d;
  logic              bvalid_d;
  logic              rvalid_d;
  logic              awready_q;
  logic              wready_q;
  logic              arready_q;
  logic              wr_sec;
  logic              wr_min;
  logic              wr_hr;
  logic              wr_wd;
  logic              wr_dt;
  logic              wr_mo;
  logic              wr_yr;

  // days in the current month; year zero and every fourth year are leap
  function automatic logic [DT_W-1:0] last_date(input logic [MO_W-1:0] mo, input logic [YR_W-1:0] yr);
    logic leap;
    leap = (yr[1:0] == 2'b00);
    if (mo == MO_FEB)
      return leap ? DT_29 : DT_28;
    else if ((mo == MO_APR) || (mo == MO_JUN) || (mo == MO_SEP) || (mo == MO_NOV))
      return DT_30;
    else
      return DT_31;
  endfunction

  // one second forward with carries; out of range values wrap as if at maximum, except a zero date, which steps to one
  function automatic calendar_t advance(input calendar_t c);
    calendar_t n;
    n = c;
    if (c.seconds < SEC_MAX)
      n.seconds = c.seconds + 1'b1;
    else
    begin
      n.seconds = '0;
      if (c.minutes < MIN_MAX)
        n.minutes = c.minutes + 1'b1;
      else
      begin
        n.minutes = '0;
        if (c.hours < HR_MAX)
          n.hours = c.hours + 1'b1;
        else
        begin
          n.hours   = '0;
          n.weekday = (c.weekday >= WD_LAST || c.weekday == '0) ? WD_FIRST : c.weekday + 1'b1;
          if (c.date < last_date(c.month, c.year))
            n.date = c.date + 1'b1;
          else
          begin
            n.date = DT_FIRST;
            if (c.month < MO_LAST && c.month != '0)
              n.month = c.month + 1'b1;
            else
            begin
              n.month = MO_FIRST;
              n.year  = (c.year == YR_MAX) ? '0 : c.year + 1'b1;
            end
          end
        end
      end
    end
    return n;
  endfunction

  // handshake decoding; a channel moves only with valid and ready both high
  assign aw_take   = s_awvalid & awready_q;
  assign w_take    = s_wvalid & wready_q;
  assign ar_take   = s_arvalid & arready_q;
  assign wr_fire   = aw_held_q & w_held_q & ~bvalid_q;

  // next channel states, so ready can drop on the very edge a channel fills
  assign aw_held_d = aw_take | (aw_held_q & ~wr_fire);
  assign w_held_d  = w_take | (w_held_q & ~wr_fire);
  assign bvalid_d  = wr_fire | (bvalid_q & ~s_bready);
  assign rvalid_d  = ar_take | (rvalid_q & ~s_rready);
  assign wr_hit    = decode_index(aw_idx_q);
  assign rd_hit    = decode_index(s_araddr[ADDR_W-1:2]);
  assign wr_mapped = |wr_hit;
  assign rd_mapped = |rd_hit;
  // data live in byte lane 0; writes without it change nothing
  assign wr_apply  = wr_fire & w_lane0_q;

  // per field write enables
  assign wr_sec = wr_apply & wr_hit.hit_sec;
  assign wr_min = wr_apply & wr_hit.hit_min;
  assign wr_hr  = wr_apply & wr_hit.hit_hr;
  assign wr_wd  = wr_apply & wr_hit.hit_wd;
  assign wr_dt  = wr_apply & wr_hit.hit_dt;
  assign wr_mo  = wr_apply & wr_hit.hit_mo;
  assign wr_yr  = wr_apply & wr_hit.hit_yr;

  // trim strobes; both together is illegal from software and is dropped
  assign trim_both  = w_data_q[TRIM_INSERT_BIT] & w_data_q[TRIM_REMOVE_BIT];
  assign insert_req = wr_apply & wr_hit.hit_trim & w_data_q[TRIM_INSERT_BIT] & ~trim_both;
  assign remove_req = wr_apply & wr_hit.hit_trim & w_data_q[TRIM_REMOVE_BIT] & ~trim_both;

  second_trim u_trim (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .sec_tick   (sec_tick),
    .insert_req (insert_req),
    .remove_req (remove_req),
    .step       (step)
  );

  assign cal_stepped = step ? advance(cal_q) : cal_q;

  // a software write to a field wins over the tick for that field
  always_comb
  begin
    cal_d = cal_stepped;
    if (wr_sec)
      cal_d.seconds = w_data_q[SEC_W-1:0];
    if (wr_min)
      cal_d.minutes = w_data_q[MIN_W-1:0];
    if (wr_hr)
      cal_d.hours = w_data_q[HR_W-1:0];
    if (wr_wd)
      cal_d.weekday = w_data_q[WD_W-1:0];
    if (wr_dt)
      cal_d.date = w_data_q[DT_W-1:0];
    if (wr_mo)
      cal_d.month = w_data_q[MO_W-1:0];
    if (wr_yr)
      cal_d.year = w_data_q[YR_W-1:0];
  end

  // read mux; trim register is write only and reads zero
  assign rd_value = rd_hit.hit_sec ? DATA_W'(cal_q.seconds) :
                    rd_hit.hit_min ? DATA_W'(cal_q.minutes) :
                    rd_hit.hit_hr  ? DATA_W'(cal_q.hours)   :
                    rd_hit.hit_wd  ? DATA_W'(cal_q.weekday) :
                    rd_hit.hit_dt  ? DATA_W'(cal_q.date)    :
                    rd_hit.hit_mo  ? DATA_W'(cal_q.month)   :
                    rd_hit.hit_yr  ? DATA_W'(cal_q.year)    :
                    '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cal_q <= CAL_RESET;
    else
      cal_q <= cal_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= '0;
    end
    else if (aw_take)
    begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_awaddr[ADDR_W-1:2];
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q  <= 1'b0;
      w_data_q  <= '0;
      w_lane0_q <= 1'b0;
    end
    else if (w_take)
    begin
      w_held_q  <= 1'b1;
      w_data_q  <= s_wdata;
      w_lane0_q <= s_wstrb[0];
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      // unmapped writes still answer, so the master is never left waiting
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_bready)
      bvalid_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_value;
      rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_rready)
      rvalid_q <= 1'b0;
  end

  // ready flags straight from flops, built from the next channel states;
  // low in reset so nothing is taken before the first clean edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
    end
    else
    begin
      awready_q <= ~(aw_held_d | bvalid_d);
      wready_q  <= ~(w_held_d | bvalid_d);
      arready_q <= ~rvalid_d;
    end
  end

  assign s_awready    = awready_q;
  assign s_wready     = wready_q;
  assign s_arready    = arready_q;
  assign s_bvalid     = bvalid_q;
  assign s_bresp      = bresp_q;
  assign s_rvalid     = rvalid_q;
  assign s_rdata      = rdata_q;
  assign s_rresp      = rresp_q;
  assign calendar_now = cal_q;

endmodule

/* calendar_clock_with_trim_properties.sv */
// port assertions for the calendar clock with second trim
`timescale 1ns/1ps
module calendar_clock_with_trim_properties
  import calendar_pkg::*;
(
  input wire logic              aclk,        // clock
  input wire logic              aresetn,     // sync reset
  input wire logic              sec_tick,    // seconds tick
  input wire logic              s_awvalid,   // aw valid
  input wire logic              s_awready,   // aw ready
  input wire logic              s_wvalid,    // w valid
  input wire logic              s_wready,    // w ready
  input wire logic              s_bvalid,    // b valid
  input wire logic              s_bready,    // b ready
  input wire logic [1:0]        s_bresp,     // b response
  input wire logic              s_arvalid,   // ar valid
  input wire logic              s_arready,   // ar ready
  input wire logic              s_rvalid,    // r valid
  input wire logic              s_rready,    // r ready
  input wire logic [DATA_W-1:0] s_rdata,     // read data
  input wire calendar_t         calendar_now // time and date
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence

  // an insert step lands one edge after the tick step, hence depth two
  sequence no_cause;
    !$past(sec_tick) && !$past(sec_tick, 2) && !$rose(s_bvalid);
  endsequence

  sequence day_carry;
    $changed(calendar_now.date) && !$rose(s_bvalid);
  endsequence

  a_time_range: assert property (
    calendar_now.seconds <= 6'h3B && calendar_now.minutes <= 6'h3B && calendar_now.hours <= 5'h17)
    else $error("time field out of range");
  a_day_range: assert property (
    calendar_now.weekday inside {[3'h1:3'h7]} && calendar_now.date != 5'h00
    && calendar_now.month inside {[4'h1:4'hC]}) else $error("day field out of range");
  a_idle_hold: assert property (no_cause |-> $stable(calendar_now))
    else $error("calendar moved without cause");
  a_min_carry: assert property (
    $changed(calendar_now.minutes) && !$rose(s_bvalid) |-> calendar_now.seconds <= 6'h01)
    else $error("minutes moved without seconds wrap");
  a_date_carry: assert property (
    day_carry |-> calendar_now.hours == 5'h00 && calendar_now.minutes == 6'h00)
    else $error("date moved without midnight");
  a_wday_step: assert property (day_carry |-> calendar_now.weekday ==
    (($past(calendar_now.weekday) == 3'h7) ? 3'h1 : $past(calendar_now.weekday) + 3'h1))
    else $error("weekday did not follow date");
  a_wr_answer: assert property (wr_taken |-> ##[1:2] s_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid)
    else $error("read response late");
  a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
endmodule

bind calendar_clock_with_trim calendar_clock_with_trim_properties chk_i (
  .aclk, .aresetn, .sec_tick, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid,
  .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .calendar_now
);

/* calendar_clock_with_trim_tb_top.sv */
// self-checking bench for the calendar clock with second trim
`timescale 1ns/1ps
module calendar_clock_with_trim_tb_top
  import calendar_pkg::*;
;
  logic              aclk, aresetn, sec_tick;
  logic              s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic              s_arvalid, s_arready, s_rvalid, s_rready;
  logic [ADDR_W-1:0] s_awaddr, s_araddr;
  logic [DATA_W-1:0] s_wdata, s_rdata;
  logic [3:0]        s_wstrb;
  logic [2:0]        s_awprot, s_arprot;
  logic [1:0]        s_bresp, s_rresp;
  calendar_t         calendar_now, model;
  calendar_t         corner [5];
  int                err_count, n_checks;

  calendar_clock_with_trim dut (
    .aclk, .aresetn, .sec_tick, .s_awaddr, .s_awprot, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arprot, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .calendar_now
  );

  always #2 aclk = ~aclk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic limit(input bit ok);
    if (ok)
      return;
    chk("bus wait", 48'h1, 48'h0);
    give_verdict();
  endtask

  // one register access; ready to take the answer after a random delay
  task automatic xfer(input bit wr, input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    int dl;
    bit done;
    n = 0;
    dl = $urandom_range(3);
    done = 1'b0;
    @(posedge aclk);
    s_awaddr <= {idx, 2'b00};
    s_araddr <= {idx, 2'b00};
    s_wdata <= {24'($urandom), d[7:0]};
    s_awvalid <= wr;
    s_wvalid <= wr;
    s_arvalid <= !wr;
    s_bready <= wr && dl == 0;
    s_rready <= !wr && dl == 0;
    while (!done && n < 60)
    begin
      @(posedge aclk);
      n++;
      done = (wr ? s_bvalid & s_bready : s_rvalid & s_rready) === 1'b1;
      if (s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wready === 1'b1)
        s_wvalid <= 1'b0;
      if (s_arready === 1'b1)
        s_arvalid <= 1'b0;
      s_bready <= wr && n >= dl && !done;
      s_rready <= !wr && n >= dl && !done;
    end
    limit(done);
    chk("resp", er, wr ? s_bresp : s_rresp);
    if (!wr)
      chk("rdata", d, s_rdata);
  endtask

  function automatic logic [31:0] fld(input calendar_t c, input int i);
    case (i)
      0: return 32'(c.seconds);
      1: return 32'(c.minutes);
      2: return 32'(c.hours);
      3: return 32'(c.weekday);
      4: return 32'(c.date);
      5: return 32'(c.month);
      default: return 32'(c.year);
    endcase
  endfunction

  function automatic calendar_t step_c(input calendar_t c);
    logic [4:0] last;
    last = (c.month == 4'h2) ? ((c.year[1:0] == 2'h0) ? 5'h1D : 5'h1C) :
           (c.month inside {4'h4, 4'h6, 4'h9, 4'hB}) ? 5'h1E : 5'h1F;
    c.seconds = (c.seconds == 6'h3B) ? 6'h00 : c.seconds + 6'h01;
    if (c.seconds != 6'h00)
      return c;
    c.minutes = (c.minutes == 6'h3B) ? 6'h00 : c.minutes + 6'h01;
    if (c.minutes != 6'h00)
      return c;
    c.hours = (c.hours == 5'h17) ? 5'h00 : c.hours + 5'h01;
    if (c.hours != 5'h00)
      return c;
    c.weekday = (c.weekday == 3'h7) ? 3'h1 : c.weekday + 3'h1;
    c.date = (c.date == last) ? 5'h01 : c.date + 5'h01;
    if (c.date != 5'h01)
      return c;
    c.month = (c.month == 4'hC) ? 4'h1 : c.month + 4'h1;
    if (c.month == 4'h1)
      c.year = c.year + 8'h01;
    return c;
  endfunction

  function automatic calendar_t rand_cal();
    return '{8'($urandom), 4'($urandom_range(12, 1)), 5'($urandom_range(28, 1)),
             3'($urandom_range(7, 1)), 5'($urandom_range(23)), 6'($urandom_range(59)),
             6'($urandom_range(59))};
  endfunction

  task automatic load(input calendar_t c);
    for (int i = 0; i < 7; i++)
      xfer(1'b1, IDX_SECONDS + IDX_W'(i), fld(c, i), RESP_OKAY);
    model = c;
    for (int i = 0; i < 7; i++)
      xfer(1'b0, IDX_SECONDS + IDX_W'(i), fld(c, i), RESP_OKAY);
  endtask

  // ticks kept well apart, the design needs one idle cycle between them
  task automatic tick(input int steps);
    @(posedge aclk);
    sec_tick <= 1'b1;
    @(posedge aclk);
    sec_tick <= 1'b0;
    repeat (4) @(posedge aclk);
    repeat (steps) model = step_c(model);
    chk("calendar", model, calendar_now);
  endtask

  initial
  begin
    void'($urandom(32'h9F142400));
    aclk = 1'b0;
    aresetn = 1'b0;
    {sec_tick, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_awprot, s_arprot} = '0;
    s_wstrb = 4'hF;
    corner[0] = '{8'hFF, 4'hC, 5'h1F, 3'h7, 5'h17, 6'h3B, 6'h3B};
    corner[1] = '{8'h00, 4'h2, 5'h1C, 3'h3, 5'h17, 6'h3B, 6'h3B};
    corner[2] = '{8'h01, 4'h2, 5'h1C, 3'h4, 5'h17, 6'h3B, 6'h3B};
    corner[3] = '{8'h04, 4'h2, 5'h1D, 3'h5, 5'h17, 6'h3B, 6'h3B};
    corner[4] = '{8'h07, 4'h4, 5'h1E, 3'h6, 5'h0C, 6'h3B, 6'h3B};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    model = CAL_RESET;
    for (int i = 0; i < 7; i++)
      xfer(1'b0, IDX_SECONDS + IDX_W'(i), fld(model, i), RESP_OKAY);
    s_wstrb <= 4'hE;
    xfer(1'b1, IDX_SECONDS, 32'h2A, RESP_OKAY);
    s_wstrb <= 4'hF;
    xfer(1'b0, IDX_SECONDS, fld(model, 0), RESP_OKAY);
    xfer(1'b0, IDX_TRIM, 32'h0, RESP_OKAY);
    xfer(1'b0, 14'h0123, 32'h0, RESP_SLVERR);
    xfer(1'b1, 14'h0123, 32'hFF, RESP_SLVERR);
    tick(1);
    for (int i = 0; i < 5; i++)
    begin
      load(corner[i]);
      tick(1);
    end
    repeat (10)
    begin
      load(rand_cal());
      tick(1);
    end
    load(corner[0]);
    xfer(1'b1, IDX_TRIM, 32'h1, RESP_OKAY);
    tick(2);
    tick(1);
    xfer(1'b1, IDX_TRIM, 32'h2, RESP_OKAY);
    tick(0);
    tick(1);
    tick(1);
    xfer(1'b1, IDX_TRIM, 32'h0, RESP_OKAY);
    tick(1);
    give_verdict();
  end
endmodule
